// ===== spcg_top.sv
// sleep port clock gating control with ahb-lite register slave
// Behaviour
// - bits 0..4 enable port a..e clock during sleep; set keeps clock running.
// - any access to a port whose clock is off raises a bus fault.
// - sleep gating register reads zero after reset; all ports unclocked.
// - separate run, sleep, deep sleep registers; sleep one used only in sleep.
// - sleep and deep sleep registers apply only with auto clock gating set.
`timescale 1ns/1ps

module spcg_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] power_mode,
	input wire logic [4:0] port_access_req,
	output logic [4:0] port_clock_enable,
	output logic [4:0] port_bus_fault,
	output logic irq
);

	// address phase capture
	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	// register file
	logic [4:0] run_port_clock_enables_q;
	logic [4:0] run_port_clock_enables_d;
	logic [4:0] sleep_port_clock_enables_q;
	logic [4:0] sleep_port_clock_enables_d;
	logic [4:0] deep_sleep_port_clock_enables_q;
	logic [4:0] deep_sleep_port_clock_enables_d;
	logic auto_clock_gating_enable_q;
	logic auto_clock_gating_enable_d;
	logic [4:0] int_status_q;
	logic [4:0] int_status_d;
	logic [4:0] int_mask_q;
	logic [4:0] int_mask_d;
	// outputs
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic hreadyout_q;
	logic hresp_q;
	logic [4:0] port_clock_enable_q;
	logic [4:0] port_clock_enable_d;
	logic irq_q;
	logic irq_d;
	logic [4:0] fault_q;

	////////////////////////////////////////////////////////////////////////
	// ahb-lite address phase decode
	wire bus_take = hsel & htrans[1] & hready;
	wire rd_take = bus_take & ~hwrite;
	wire wr_take = bus_take & hwrite;
	wire [11:0] rd_addr = haddr[11:0];
	// upper address bits belong to the interconnect decode
	wire word_ok = (haddr[1:0] == 2'h0) & (hsize == 3'h2);

	// capture a write so its data phase can use hwdata
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end
		else
		begin
			wr_pend_q <= wr_take & word_ok;
			wr_addr_q <= haddr[11:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data phase write strobes
	wire wsel_cfg = wr_pend_q & (wr_addr_q == spcg_pkg::SPCG_CFG_OFF);
	wire wsel_run = wr_pend_q & (wr_addr_q == spcg_pkg::SPCG_RUN_OFF);
	wire wsel_slp = wr_pend_q & (wr_addr_q == spcg_pkg::SPCG_SLEEP_OFF);
	wire wsel_deep = wr_pend_q & (wr_addr_q == spcg_pkg::SPCG_DEEP_OFF);
	wire wsel_stat = wr_pend_q & (wr_addr_q == spcg_pkg::SPCG_STAT_OFF);
	wire wsel_mask = wr_pend_q & (wr_addr_q == spcg_pkg::SPCG_MASK_OFF);
	wire [4:0] wr_en_field = hwdata[4:0];
	wire [4:0] stat_clear = wsel_stat ? hwdata[4:0] : 5'h00;

	// next register values; only bits 4..0 exist, upper writes drop
	assign run_port_clock_enables_d =
		wsel_run ? wr_en_field : run_port_clock_enables_q;
	assign sleep_port_clock_enables_d =
		wsel_slp ? wr_en_field : sleep_port_clock_enables_q;
	assign deep_sleep_port_clock_enables_d =
		wsel_deep ? wr_en_field : deep_sleep_port_clock_enables_q;
	assign auto_clock_gating_enable_d = wsel_cfg ?
		hwdata[spcg_pkg::SPCG_AUTO_BIT] : auto_clock_gating_enable_q;
	assign int_mask_d = wsel_mask ? hwdata[4:0] : int_mask_q;
	// write-one-to-clear; a fault in the same cycle wins over the clear
	assign int_status_d = (int_status_q & ~stat_clear) | fault_q;

	// register file flops
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_port_clock_enables_q <= spcg_pkg::SPCG_EN_RST;
			sleep_port_clock_enables_q <= spcg_pkg::SPCG_EN_RST;
			deep_sleep_port_clock_enables_q <= spcg_pkg::SPCG_EN_RST;
			auto_clock_gating_enable_q <= spcg_pkg::SPCG_AUTO_RST;
			int_status_q <= 5'h00;
			int_mask_q <= 5'h00;
		end
		else
		begin
			run_port_clock_enables_q <= run_port_clock_enables_d;
			sleep_port_clock_enables_q <= sleep_port_clock_enables_d;
			deep_sleep_port_clock_enables_q <= deep_sleep_port_clock_enables_d;
			auto_clock_gating_enable_q <= auto_clock_gating_enable_d;
			int_status_q <= int_status_d;
			int_mask_q <= int_mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; reads the next values so a read right after a write
	// to the same register sees the new data with no wait state
	wire rsel_cfg = rd_addr == spcg_pkg::SPCG_CFG_OFF;
	wire rsel_run = rd_addr == spcg_pkg::SPCG_RUN_OFF;
	wire rsel_slp = rd_addr == spcg_pkg::SPCG_SLEEP_OFF;
	wire rsel_deep = rd_addr == spcg_pkg::SPCG_DEEP_OFF;
	wire rsel_stat = rd_addr == spcg_pkg::SPCG_STAT_OFF;
	wire rsel_mask = rd_addr == spcg_pkg::SPCG_MASK_OFF;
	logic [31:0] rd_val;

	// unmapped and misaligned addresses read zero with an okay answer
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (!word_ok)
			rd_val = 32'h0000_0000;
		else if (rsel_cfg)
			rd_val[spcg_pkg::SPCG_AUTO_BIT] = auto_clock_gating_enable_d;
		else if (rsel_run)
			rd_val[4:0] = run_port_clock_enables_d;
		else if (rsel_slp)
			rd_val[4:0] = sleep_port_clock_enables_d;
		else if (rsel_deep)
			rd_val[4:0] = deep_sleep_port_clock_enables_d;
		else if (rsel_stat)
			rd_val[4:0] = int_status_d;
		else if (rsel_mask)
			rd_val[4:0] = int_mask_d;
	end

	assign hrdata_d = rd_take ? rd_val : spcg_pkg::SPCG_RDATA_RST;

	// bus answer flops; the slave never stalls and never errors
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_q <= spcg_pkg::SPCG_RDATA_RST;
			hreadyout_q <= 1'b1;
			hresp_q <= spcg_pkg::SPCG_HRESP_OKAY;
		end
		else
		begin
			hrdata_q <= hrdata_d;
			hreadyout_q <= 1'b1;
			hresp_q <= spcg_pkg::SPCG_HRESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gating source selection by power mode
	wire mode_sleep = power_mode == spcg_pkg::SPCG_MODE_SLEEP;
	wire mode_deep = power_mode == spcg_pkg::SPCG_MODE_DEEP;
	wire use_sleep = auto_clock_gating_enable_q & mode_sleep;
	wire use_deep = auto_clock_gating_enable_q & mode_deep;

	// without auto gating the run values hold in every mode
	assign port_clock_enable_d =
		use_sleep ? sleep_port_clock_enables_q :
		use_deep ? deep_sleep_port_clock_enables_q :
		run_port_clock_enables_q;

	// enables are registered so the gate cells see a glitch-free level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			port_clock_enable_q <= spcg_pkg::SPCG_EN_RST;
		else
			port_clock_enable_q <= port_clock_enable_d;
	end

	////////////////////////////////////////////////////////////////////////
	// bus fault detection against the enables actually applied
	spcg_fault_check u_fault
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.port_access_req(port_access_req),
		.port_clock_enable(port_clock_enable_q),
		.fault_q(fault_q)
	);

	// level interrupt, one cycle behind the status bits
	assign irq_d = |(int_status_q & int_mask_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	////////////////////////////////////////////////////////////////////////
	// output drive, all from flops
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign port_clock_enable = port_clock_enable_q;
	assign port_bus_fault = fault_q;
	assign irq = irq_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	// helper: high from the first edge after reset release
	logic started_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			started_q <= 1'b0;
		else
			started_q <= 1'b1;
	end

	property p_reset_zero;
		@(posedge hclk)
		!started_q |-> sleep_port_clock_enables_q == 5'h00 &&
			port_clock_enable_q == 5'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("sleep gating not zero after reset");

	property p_sleep_select;
		@(posedge hclk) disable iff (!hresetn)
		auto_clock_gating_enable_q && mode_sleep
		|=> port_clock_enable_q == $past(sleep_port_clock_enables_q);
	endproperty
	a_sleep_select: assert property (p_sleep_select)
		else $error("sleep enables not applied in sleep");

	property p_deep_select;
		@(posedge hclk) disable iff (!hresetn)
		auto_clock_gating_enable_q && mode_deep
		|=> port_clock_enable_q == $past(deep_sleep_port_clock_enables_q);
	endproperty
	a_deep_select: assert property (p_deep_select)
		else $error("deep sleep enables not applied in deep sleep");

	property p_run_in_run;
		@(posedge hclk) disable iff (!hresetn)
		power_mode == spcg_pkg::SPCG_MODE_RUN
		|=> port_clock_enable_q == $past(run_port_clock_enables_q);
	endproperty
	a_run_in_run: assert property (p_run_in_run)
		else $error("run enables not applied in run mode");

	property p_no_auto_run;
		@(posedge hclk) disable iff (!hresetn)
		!auto_clock_gating_enable_q
		|=> port_clock_enable_q == $past(run_port_clock_enables_q);
	endproperty
	a_no_auto_run: assert property (p_no_auto_run)
		else $error("run enables not kept with auto gating off");

	// write to the sleep register, then read it straight back
	sequence s_wr_sleep;
		wr_take && word_ok && haddr[11:0] == spcg_pkg::SPCG_SLEEP_OFF;
	endsequence

	sequence s_rd_sleep;
		rd_take && word_ok && haddr[11:0] == spcg_pkg::SPCG_SLEEP_OFF;
	endsequence

	property p_sleep_write;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_sleep ##1 1'b1
		|=> sleep_port_clock_enables_q == $past(hwdata[4:0]);
	endproperty
	a_sleep_write: assert property (p_sleep_write)
		else $error("sleep register write lost");

	property p_sleep_upper_zero;
		@(posedge hclk) disable iff (!hresetn)
		s_rd_sleep |=> hrdata_q[31:5] == 27'h000_0000 &&
			hrdata_q[4:0] == sleep_port_clock_enables_q;
	endproperty
	a_sleep_upper_zero: assert property (p_sleep_upper_zero)
		else $error("sleep register readback wrong");

	property p_fault_sticky;
		@(posedge hclk) disable iff (!hresetn)
		fault_q != 5'h00 |=> (int_status_q & $past(fault_q)) == $past(fault_q);
	endproperty
	a_fault_sticky: assert property (p_fault_sticky)
		else $error("fault event lost from status");

	property p_irq_level;
		@(posedge hclk) disable iff (!hresetn)
		(int_status_q & int_mask_q) != 5'h00 |=> irq_q;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt not raised for unmasked status");

endmodule : spcg_top

// ===== spcg_pkg.sv
// constants for the sleep port clock gating block
package spcg_pkg;

	// number of gated ports, a to e
	localparam int unsigned SPCG_PORTS = 5;

	// register byte offsets inside the 4 kbyte block window
	localparam logic [11:0] SPCG_CFG_OFF = 12'h060;
	localparam logic [11:0] SPCG_RUN_OFF = 12'h108;
	localparam logic [11:0] SPCG_SLEEP_OFF = 12'h118;
	localparam logic [11:0] SPCG_DEEP_OFF = 12'h128;
	localparam logic [11:0] SPCG_STAT_OFF = 12'h200;
	localparam logic [11:0] SPCG_MASK_OFF = 12'h204;

	// field positions
	localparam int unsigned SPCG_AUTO_BIT = 0;
	localparam int unsigned SPCG_EN_LSB = 0;

	// values after reset
	localparam logic [4:0] SPCG_EN_RST = 5'h00;
	localparam logic SPCG_AUTO_RST = 1'b0;
	localparam logic [31:0] SPCG_RDATA_RST = 32'h0000_0000;

	// power mode codes driven by the system power controller
	localparam logic [1:0] SPCG_MODE_RUN = 2'h0;
	localparam logic [1:0] SPCG_MODE_SLEEP = 2'h1;
	localparam logic [1:0] SPCG_MODE_DEEP = 2'h2;

	// ahb-lite codes
	localparam logic [1:0] SPCG_HTRANS_NONSEQ = 2'h2;
	localparam logic SPCG_HRESP_OKAY = 1'b0;

endpackage : spcg_pkg

// ===== spcg_fault_check.sv
// per-port bus fault detector for accesses to unclocked ports
`timescale 1ns/1ps

module spcg_fault_check
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [4:0] port_access_req,
	input wire logic [4:0] port_clock_enable,
	output logic [4:0] fault_q
);

	logic [4:0] fault_d;

	////////////////////////////////////////////////////////////////////////
	// fault decode, one bit per port
	genvar gi;
	generate
		for (gi = 0; gi < spcg_pkg::SPCG_PORTS; gi++)
		begin : g_port
			// an access while the port clock is off can never complete
			assign fault_d[gi] = port_access_req[gi] & ~port_clock_enable[gi];
		end
	endgenerate

	// fault registered one cycle after the request, held for as long as the request stays
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			fault_q <= 5'h00;
		else
			fault_q <= fault_d;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_fault_on_gated;
		@(posedge hclk) disable iff (!hresetn)
		(port_access_req & ~port_clock_enable) != 5'h00
		|=> fault_q == $past(port_access_req & ~port_clock_enable);
	endproperty
	a_fault_on_gated: assert property (p_fault_on_gated)
		else $error("missing bus fault on gated port access");

	property p_no_fault_when_clocked;
		@(posedge hclk) disable iff (!hresetn)
		(port_access_req & ~port_clock_enable) == 5'h00 |=> fault_q == 5'h00;
	endproperty
	a_no_fault_when_clocked: assert property (p_no_fault_when_clocked)
		else $error("spurious bus fault on clocked port");

endmodule : spcg_fault_check

// ===== tb_spcg_top.sv
// self-checking bench for the sleep port clock gating block
`timescale 1ns/1ps

module tb_spcg_top;

	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	wire logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [1:0] power_mode;
	logic [4:0] port_access_req;
	logic [4:0] port_clock_enable;
	logic [4:0] port_bus_fault;
	logic irq;
	int errors;
	int checks_done;
	int cycles;

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;

	spcg_top spcg_top_inst
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.power_mode(power_mode),
		.port_access_req(port_access_req),
		.port_clock_enable(port_clock_enable),
		.port_bus_fault(port_bus_fault),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	// clock and hang guard; the tests need well under 2000 cycles
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			errors = errors + 1;
			$display("Error timeout: bus or test never finished");
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// comparison and closing
	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("Error %s: expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	// ahb-lite single word master; waits on hready, never counts cycles
	task automatic addr_phase(input logic [11:0] off, input logic wr);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, off};
		htrans <= spcg_pkg::SPCG_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
	endtask : addr_phase

	task automatic wr(input logic [11:0] off, input logic [31:0] d);
		addr_phase(off, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : wr

	task automatic rd(input string name, input logic [11:0] off,
		input logic [31:0] exp);
		logic [31:0] got;
		logic resp;
		addr_phase(off, 1'b0);
		do @(posedge hclk); while (hready !== 1'b1);
		got = hrdata;
		resp = hresp;
		check(name, exp, got);
		check("hresp", {31'h0, spcg_pkg::SPCG_HRESP_OKAY}, {31'h0, resp});
	endtask : rd

	// mode change, then let the registered enable settle
	task automatic mode_chk(input string name, input logic [1:0] mode,
		input logic [4:0] exp);
		@(posedge hclk);
		power_mode <= mode;
		repeat (3) @(posedge hclk);
		check(name, {27'h0, exp}, {27'h0, port_clock_enable});
	endtask : mode_chk

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		power_mode = spcg_pkg::SPCG_MODE_RUN;
		port_access_req = 5'h00;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;

		// reset values of the sleep, run, deep sleep and config registers
		check("ready reset", 32'h0000_0001, {31'h0, hreadyout});
		rd("sleep reset", spcg_pkg::SPCG_SLEEP_OFF, 32'h0000_0000);
		rd("run reset", spcg_pkg::SPCG_RUN_OFF, 32'h0000_0000);
		rd("deep reset", spcg_pkg::SPCG_DEEP_OFF, 32'h0000_0000);
		rd("cfg reset", spcg_pkg::SPCG_CFG_OFF, 32'h0000_0000);
		check("enable reset", 32'h0000_0000, {27'h0, port_clock_enable});
		$display("test reset values done");

		// reserved bits read zero and ignore writes
		wr(spcg_pkg::SPCG_SLEEP_OFF, 32'hFFFF_FFFF);
		rd("sleep all ones", spcg_pkg::SPCG_SLEEP_OFF, 32'h0000_001F);
		wr(spcg_pkg::SPCG_SLEEP_OFF, 32'hFFFF_FFE0);
		rd("sleep high only", spcg_pkg::SPCG_SLEEP_OFF, 32'h0000_0000);
		rd("unmapped", 12'h300, 32'h0000_0000);
		$display("test reserved bits done");

		// distinct values per mode; auto gating off first
		wr(spcg_pkg::SPCG_RUN_OFF, 32'h0000_0005);
		wr(spcg_pkg::SPCG_SLEEP_OFF, 32'h0000_001A);
		wr(spcg_pkg::SPCG_DEEP_OFF, 32'h0000_0013);
		rd("sleep readback", spcg_pkg::SPCG_SLEEP_OFF, 32'h0000_001A);
		mode_chk("run no auto", spcg_pkg::SPCG_MODE_RUN, 5'h05);
		mode_chk("sleep no auto", spcg_pkg::SPCG_MODE_SLEEP, 5'h05);
		mode_chk("deep no auto", spcg_pkg::SPCG_MODE_DEEP, 5'h05);
		wr(spcg_pkg::SPCG_CFG_OFF, 32'h0000_0001);
		mode_chk("deep auto", spcg_pkg::SPCG_MODE_DEEP, 5'h13);
		mode_chk("run auto", spcg_pkg::SPCG_MODE_RUN, 5'h05);
		// the spare mode code falls back to the run values
		mode_chk("mode three auto", 2'h3, 5'h05);
		mode_chk("sleep auto", spcg_pkg::SPCG_MODE_SLEEP, 5'h1A);
		$display("test mode selection done");

		// access all ports in sleep: only a and c are unclocked
		@(posedge hclk);
		port_access_req <= 5'h1F;
		@(posedge hclk);
		port_access_req <= 5'h00;
		@(posedge hclk);
		check("fault pulse", 32'h0000_0005, {27'h0, port_bus_fault});
		@(posedge hclk);
		check("fault end", 32'h0000_0000, {27'h0, port_bus_fault});
		rd("status", spcg_pkg::SPCG_STAT_OFF, 32'h0000_0005);
		check("irq masked", 32'h0000_0000, {31'h0, irq});
		wr(spcg_pkg::SPCG_MASK_OFF, 32'h0000_0004);
		repeat (3) @(posedge hclk);
		check("irq on", 32'h0000_0001, {31'h0, irq});
		wr(spcg_pkg::SPCG_STAT_OFF, 32'h0000_0004);
		repeat (3) @(posedge hclk);
		check("irq cleared", 32'h0000_0000, {31'h0, irq});
		rd("status left", spcg_pkg::SPCG_STAT_OFF, 32'h0000_0001);
		$display("test bus fault and interrupt done");

		// setting a bit clocks the port, so no more fault there
		wr(spcg_pkg::SPCG_SLEEP_OFF, 32'h0000_001F);
		repeat (3) @(posedge hclk);
		check("sleep all on", 32'h0000_001F, {27'h0, port_clock_enable});
		port_access_req <= 5'h1F;
		@(posedge hclk);
		port_access_req <= 5'h00;
		@(posedge hclk);
		check("no fault", 32'h0000_0000, {27'h0, port_bus_fault});
		$display("test enabled ports done");
		stop_test();
	end

endmodule : tb_spcg_top
